// file: imb_pkg.sv
/*
 * constants for the i2c mode and bus-state control block.
 * assumes a 40 mhz system clock and a synchronous active-high reset.
 */
`default_nettype none
package imb_pkg;
   // clock rate and bus condition timing
   localparam int CLK_HZ          = 40_000_000;
   localparam int COND_HOLD_NS    = 4700;
   localparam int COND_HOLD_CYC   = (COND_HOLD_NS * (CLK_HZ / 1_000_000)
                                     + 999) / 1000;
   // reset values
   localparam logic RST_MASTER    = 1'b0;
   localparam logic RST_TRANSMIT  = 1'b0;
   localparam logic RST_BUSY      = 1'b0;
   localparam logic RST_IRQ       = 1'b0;

   // operating modes, one-hot
   typedef enum logic [3:0] {
      IMB_SLV_RX = 4'h1,
      IMB_SLV_TX = 4'h2,
      IMB_MST_RX = 4'h4,
      IMB_MST_TX = 4'h8
   } imb_mode_t;

   // condition generator states, one-hot
   typedef enum logic [3:0] {
      IMB_GEN_IDLE  = 4'h1,
      IMB_GEN_START = 4'h2,
      IMB_GEN_STOP  = 4'h4,
      IMB_GEN_DONE  = 4'h8
   } imb_gen_t;
endpackage
`default_nettype wire

// file: imb_sync.sv
/*
 * two-flop synchroniser for pin levels.
 * assumes the input is asynchronous to clock_i.
 */
`timescale 1ns/10ps
`default_nettype none
module imb_sync #(
   parameter int W = 2
) (
   input  wire logic         clock_i,   // system clock
   input  wire logic         sys_rst_i, // sync reset, high
   input  wire logic [W-1:0] async_i,   // raw pin levels
   output logic      [W-1:0] sync_o     // synchronised levels
);
   logic [W-1:0] meta;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         meta   <= '1;
         sync_o <= '1;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule
`default_nettype wire

// file: imb_ctrl.sv
/*
 * i2c mode, bus-busy and interrupt-flag control.
 * assumes software writes arrive as one-cycle strobes on clock_i and that
 * shifting, acknowledge and transfer-end events come from a sibling block.
 */
`timescale 1ns/10ps
`default_nettype none
module imb_ctrl
   import imb_pkg::*;
#(
   parameter int HOLD_CYC = COND_HOLD_CYC
) (
   input  wire logic clock_i,          // 40 mhz system clock
   input  wire logic sys_rst_i,        // sync reset, high
   input  wire logic wr_i,             // control write strobe
   input  wire logic rd_i,             // control read strobe
   input  wire logic wr_master_i,      // written master_select
   input  wire logic wr_transmit_i,    // written transmit_select
   input  wire logic wr_busy_i,        // written bus_busy_flag
   input  wire logic wr_qual_i,        // written start_stop_qualifier
   input  wire logic wr_irq_i,         // written interface_irq_flag
   input  wire logic arb_lost_i,       // arbitration lost pulse
   input  wire logic xfer_end_i,       // raw end of data transfer pulse
   input  wire logic xfer_end_ack_i,   // end incl. acknowledge bit pulse
   input  wire logic addr_match_i,     // slave or general call match pulse
   input  wire logic rw_bit_i,         // received read/write bit value
   input  wire logic rw_valid_i,       // first frame rw bit pulse
   input  wire logic transfer_format_sel_i, // 1: non-i2c format
   input  wire logic wait_insert_i,    // wait insertion enable
   input  wire logic ack_check_enable_i, // acknowledge check enable
   input  wire logic ack_fail_i,       // no acknowledge seen pulse
   input  wire logic display_channel_switch_i, // switch bit level
   input  wire logic xfer_ctrl_svc_i,  // transfer controller service pulse
   input  wire logic irq_enable_i,     // interface interrupt enable
   input  wire logic scl_i,            // scl pin level
   input  wire logic sda_i,            // sda pin level
   output logic      scl_o,            // scl drive value (always 0)
   output logic      scl_oe_n_o,       // low while scl driven
   output logic      sda_o,            // sda drive value (always 0)
   output logic      sda_oe_n_o,       // low while sda driven
   output logic      master_select_o,  // master_select bit
   output logic      transmit_select_o, // transmit_select bit
   output logic      bus_busy_flag_o,  // bus_busy_flag bit
   output logic      interface_irq_flag_o, // interface_irq_flag bit
   output imb_mode_t mode_o,           // decoded operating mode
   output logic      start_det_o,      // start condition pulse
   output logic      stop_det_o,       // stop condition pulse
   output logic      irq_o             // interrupt request to cpu
);
   ////////////////////////////////////////////////////////////////////
   logic [1:0] pins;
   logic       scl_s;
   logic       sda_s;
   logic       sda_d;
   logic       master_select;
   logic       transmit_select;
   logic       bus_busy_flag;
   logic       irq_flag;
   logic       mst_lost;
   logic       mst_rd0;
   logic       trs_hwclr;
   logic       trs_rd0;
   logic       trs_hwset;
   logic       trs_rd1;
   logic       irq_rd1;
   logic       sw_d;
   logic       start_det;
   logic       stop_det;
   logic       irq_set;
   logic       gen_start_req;
   logic       gen_stop_req;
   imb_gen_t   gen;
   imb_gen_t   next_gen;
   logic [15:0] cnt;

   function automatic imb_mode_t decode_mode(input logic m, input logic t);
      unique case ({m, t})
         2'b00:   decode_mode = IMB_SLV_RX;
         2'b01:   decode_mode = IMB_SLV_TX;
         2'b10:   decode_mode = IMB_MST_RX;
         default: decode_mode = IMB_MST_TX;
      endcase
   endfunction

   imb_sync #(.W(2)) u_sync (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({scl_i, sda_i}),
      .sync_o    (pins)
   );
   assign scl_s = pins[1];
   assign sda_s = pins[0];

   ////////////////////////////////////////////////////////////////////
   // bus condition detection
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sda_d <= 1'b1;
         sw_d  <= 1'b0;
      end else begin
         sda_d <= sda_s;
         sw_d  <= display_channel_switch_i;
      end
   end

   assign start_det = scl_s && sda_d && !sda_s;
   assign stop_det  = scl_s && !sda_d && sda_s;

   ////////////////////////////////////////////////////////////////////
   // master_select with read-before-write after arbitration loss
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         master_select <= RST_MASTER;
         mst_lost      <= 1'b0;
         mst_rd0       <= 1'b0;
      end else if (arb_lost_i && master_select && transmit_select) begin
         master_select <= 1'b0;
         mst_lost      <= 1'b1;
         mst_rd0       <= 1'b0;
      end else begin
         if (rd_i && mst_lost && !master_select)
            mst_rd0 <= 1'b1;
         if (wr_i && !wr_master_i)
            master_select <= 1'b0;
         else if (wr_i && (!mst_lost || mst_rd0)) begin
            master_select <= 1'b1;
            mst_lost      <= 1'b0;
            mst_rd0       <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // transmit_select with hardware force and read-before-write guards
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         transmit_select <= RST_TRANSMIT;
         trs_hwclr <= 1'b0;
         trs_rd0   <= 1'b0;
         trs_hwset <= 1'b0;
         trs_rd1   <= 1'b0;
      end else if ((arb_lost_i && master_select && transmit_select) ||
                   (sw_d && !display_channel_switch_i)) begin
         transmit_select <= 1'b0;
         trs_hwclr <= 1'b1;
         trs_rd0   <= 1'b0;
         trs_hwset <= 1'b0;
      end else if (!master_select && rw_valid_i && rw_bit_i) begin
         transmit_select <= 1'b1;
         trs_hwset <= 1'b1;
         trs_rd1   <= 1'b0;
         trs_hwclr <= 1'b0;
      end else begin
         if (rd_i && trs_hwclr && !transmit_select)
            trs_rd0 <= 1'b1;
         if (rd_i && trs_hwset && transmit_select)
            trs_rd1 <= 1'b1;
         if (wr_i && wr_transmit_i && (!trs_hwclr || trs_rd0)) begin
            transmit_select <= 1'b1;
            trs_hwclr <= 1'b0;
            trs_rd0   <= 1'b0;
         end else if (wr_i && !wr_transmit_i && (!trs_hwset || trs_rd1))
         begin
            transmit_select <= 1'b0;
            trs_hwset <= 1'b0;
            trs_rd1   <= 1'b0;
         end
      end
   end

   assign mode_o = decode_mode(master_select, transmit_select);

   ////////////////////////////////////////////////////////////////////
   // bus busy flag follows detected conditions only
   always_ff @(posedge clock_i) begin
      if (sys_rst_i)
         bus_busy_flag <= RST_BUSY;
      else if (start_det)
         bus_busy_flag <= 1'b1;
      else if (stop_det)
         bus_busy_flag <= 1'b0;
   end

   // start requests accepted only in master transmit mode, stop requests in either master mode
   assign gen_start_req = wr_i && !wr_qual_i && wr_busy_i &&
                          (mode_o == IMB_MST_TX);
   assign gen_stop_req  = wr_i && !wr_qual_i && !wr_busy_i &&
                          master_select;

   ////////////////////////////////////////////////////////////////////
   // condition generator: start = sda low while scl high, then scl low,
   // then sda let go under low scl so the final release makes no stop;
   // stop = scl low, sda low, release scl, then release sda
   always_comb begin
      next_gen = gen;
      unique case (gen)
         IMB_GEN_IDLE:
            if (gen_start_req)
               next_gen = IMB_GEN_START;
            else if (gen_stop_req)
               next_gen = IMB_GEN_STOP;
         IMB_GEN_START:
            if (cnt == 16'(HOLD_CYC - 1))
               next_gen = IMB_GEN_DONE;
         IMB_GEN_STOP:
            if (cnt == 16'(HOLD_CYC - 1))
               next_gen = IMB_GEN_DONE;
         IMB_GEN_DONE:
            if (cnt == 16'(HOLD_CYC - 1))
               next_gen = IMB_GEN_IDLE;
         default:
            next_gen = IMB_GEN_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i)
         gen <= IMB_GEN_IDLE;
      else
         gen <= next_gen;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i || next_gen != gen)
         cnt <= 16'h0000;
      else if (gen != IMB_GEN_IDLE)
         cnt <= cnt + 16'h0001;
   end

   logic starting;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i)
         starting <= 1'b0;
      else if (gen == IMB_GEN_IDLE)
         starting <= gen_start_req;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sda_oe_n_o <= 1'b1;
         scl_oe_n_o <= 1'b1;
      end else begin
         unique case (next_gen)
            IMB_GEN_START: begin
               sda_oe_n_o <= 1'b0;
               scl_oe_n_o <= 1'b1;
            end
            IMB_GEN_STOP: begin
               // scl is pulled one cycle before sda so no start is seen
               sda_oe_n_o <= (gen != IMB_GEN_STOP);
               scl_oe_n_o <= 1'b0;
            end
            IMB_GEN_DONE: begin
               // start: scl low, sda let go a cycle later; stop: sda low
               sda_oe_n_o <= starting && (gen == IMB_GEN_DONE);
               scl_oe_n_o <= !starting;
            end
            default: begin
               sda_oe_n_o <= 1'b1;
               scl_oe_n_o <= 1'b1;
            end
         endcase
      end
   end
   assign sda_o = 1'b0;
   assign scl_o = 1'b0;

   ////////////////////////////////////////////////////////////////////
   // interrupt flag: hardware set wins over software clear
   always_comb begin
      irq_set = stop_det;
      if (addr_match_i && mode_o == IMB_SLV_RX)
         irq_set = 1'b1;
      if (arb_lost_i && mode_o == IMB_MST_TX)
         irq_set = 1'b1;
      // format and wait pick end of data or end of acknowledge
      if (transfer_format_sel_i || wait_insert_i) begin
         if (xfer_end_i)
            irq_set = 1'b1;
      end else if (xfer_end_ack_i)
         irq_set = 1'b1;
      if (ack_check_enable_i && ack_fail_i)
         irq_set = 1'b1;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         irq_flag <= RST_IRQ;
         irq_rd1  <= 1'b0;
      end else if (irq_set) begin
         irq_flag <= 1'b1;
      end else if (xfer_ctrl_svc_i) begin
         irq_flag <= 1'b0;
         irq_rd1  <= 1'b0;
      end else begin
         if (rd_i && irq_flag)
            irq_rd1 <= 1'b1;
         if (wr_i && !wr_irq_i && irq_rd1) begin
            irq_flag <= 1'b0;
            irq_rd1  <= 1'b0;
         end
      end
   end

   assign irq_o                = irq_flag && irq_enable_i;
   assign master_select_o      = master_select;
   assign transmit_select_o    = transmit_select;
   assign bus_busy_flag_o      = bus_busy_flag;
   assign interface_irq_flag_o = irq_flag;
   assign start_det_o          = start_det;
   assign stop_det_o           = stop_det;

   ////////////////////////////////////////////////////////////////////
   sequence s_sda_fall_scl_hi;
      scl_s && sda_d && !sda_s;
   endsequence

   chk_start_sets_busy: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) s_sda_fall_scl_hi |=> bus_busy_flag)
      else $error("start did not set busy");
   chk_stop_clears_busy: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) (stop_det && !start_det) |=> !bus_busy_flag)
      else $error("stop did not clear busy");
   chk_arb_clears_mst: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) (arb_lost_i && master_select &&
      transmit_select) |=> !master_select && !transmit_select)
      else $error("arbitration loss kept master transmit");
   chk_slave_read_sets: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) (!master_select && rw_valid_i && rw_bit_i &&
      !arb_lost_i && !(sw_d && !display_channel_switch_i))
      |=> transmit_select)
      else $error("slave read did not set transmit");
   chk_irq_clear_rd: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) ($fell(irq_flag) && !$past(xfer_ctrl_svc_i))
      |-> $past(irq_rd1))
      else $error("irq cleared without prior read");
   chk_irq_set_stop: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) stop_det |=> irq_flag)
      else $error("stop did not set irq");
   chk_irq_out: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) irq_o == (irq_flag && irq_enable_i))
      else $error("irq output mismatch");
   chk_slave_no_gen: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) (gen == IMB_GEN_IDLE && wr_i && !master_select)
      |=> gen == IMB_GEN_IDLE)
      else $error("condition issued in slave mode");
   chk_start_drive: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) (gen == IMB_GEN_IDLE && gen_start_req)
      |=> !sda_oe_n_o && scl_oe_n_o)
      else $error("start not driven");
   chk_mode_decode: assert property (@(posedge clock_i)
      disable iff (sys_rst_i) (master_select && !transmit_select)
      |-> mode_o == IMB_MST_RX)
      else $error("mode decode wrong");
endmodule
`default_nettype wire

// file: imb_peer.sv
/*
 * behavioural peer on the two-wire bus: another master framing one byte.
 * assumes pull-ups on both wires, so a released line reads high, and a
 * link clock of 200 ns that stands high outside frames.
 */
`timescale 1ns/10ps
`default_nettype none
module imb_peer #(
   parameter time HALF = 100
) (
   output logic scl_rel_o, // 0 pulls scl low
   output logic sda_rel_o  // 0 pulls sda low
);
   initial begin
      scl_rel_o = 1'b1;
      sda_rel_o = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic start_frame();
      scl_rel_o = 1'b1;
      #HALF sda_rel_o = 1'b0;
      #HALF scl_rel_o = 1'b0;
   endtask

   // data only moves while scl is low; ninth bit left for an acknowledge
   task automatic send_byte(input logic [7:0] b);
      for (int i = 8; i >= 0; i--) begin
         sda_rel_o = (i == 0) ? 1'b1 : b[i-1];
         #HALF scl_rel_o = 1'b1;
         #HALF scl_rel_o = 1'b0;
      end
   endtask

   task automatic stop_frame();
      sda_rel_o = 1'b0;
      #HALF scl_rel_o = 1'b1;
      #HALF sda_rel_o = 1'b1;
      #HALF;
   endtask
endmodule
`default_nettype wire

// file: imb_ctrl_bench.sv
/*
 * self-checking bench for imb_ctrl with one peer master on the bus.
 * assumes imb_pkg, imb_sync, imb_ctrl and imb_peer are compiled first;
 * inputs change on the falling edge of clock_i.
 */
`timescale 1ns/10ps
`default_nettype none
module imb_ctrl_bench;
   localparam int HOLD = 4;
   logic clock_i = 1'b0;
   logic sys_rst_i, wr_i, rd_i, wr_master_i, wr_transmit_i, wr_busy_i;
   logic wr_qual_i, wr_irq_i, arb_lost_i, xfer_end_i, xfer_end_ack_i;
   logic addr_match_i, rw_bit_i, rw_valid_i, transfer_format_sel_i;
   logic wait_insert_i, ack_check_enable_i, ack_fail_i, xfer_ctrl_svc_i;
   logic display_channel_switch_i, irq_enable_i, p_scl, p_sda;
   logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, master_select_o;
   logic transmit_select_o, bus_busy_flag_o, interface_irq_flag_o;
   logic start_det_o, stop_det_o, irq_o;
   logic [3:0] mode_o;
   wire logic scl_i, sda_i;
   int n_mismatch = 0;
   int compares = 0;
   int n_start = 0;
   int n_stop = 0;
   int k;

   // wired-and of both parties with pull-ups
   assign scl_i = (scl_oe_n_o | scl_o) & p_scl;
   assign sda_i = (sda_oe_n_o | sda_o) & p_sda;

   imb_ctrl #(.HOLD_CYC(HOLD)) dut (
      .clock_i, .sys_rst_i, .wr_i, .rd_i, .wr_master_i, .wr_transmit_i,
      .wr_busy_i, .wr_qual_i, .wr_irq_i, .arb_lost_i, .xfer_end_i,
      .xfer_end_ack_i, .addr_match_i, .rw_bit_i, .rw_valid_i,
      .transfer_format_sel_i, .wait_insert_i, .ack_check_enable_i,
      .ack_fail_i, .display_channel_switch_i, .xfer_ctrl_svc_i,
      .irq_enable_i, .scl_i, .sda_i, .scl_o, .scl_oe_n_o, .sda_o,
      .sda_oe_n_o, .master_select_o, .transmit_select_o, .bus_busy_flag_o,
      .interface_irq_flag_o, .mode_o, .start_det_o, .stop_det_o, .irq_o);

   imb_peer peer (.scl_rel_o(p_scl), .sda_rel_o(p_sda));

   always #12.5 clock_i = ~clock_i;

   always @(posedge clock_i) begin
      if (start_det_o === 1'b1) n_start <= n_start + 1;
      if (stop_det_o === 1'b1) n_stop <= n_stop + 1;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [3:0] e,
                      input logic [3:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic m, t, b, q, i);
      {wr_i, wr_master_i, wr_transmit_i, wr_busy_i, wr_qual_i, wr_irq_i} =
         {1'b1, m, t, b, q, i};
      @(negedge clock_i);
      wr_i = 1'b0;
      @(negedge clock_i);
   endtask

   task automatic rd();
      rd_i = 1'b1;
      @(negedge clock_i);
      rd_i = 1'b0;
      @(negedge clock_i);
   endtask

   // bits: arb, rw_valid, end, end_ack, ack_fail, addr_match, service
   task automatic pulse(input logic [6:0] s);
      {arb_lost_i, rw_valid_i, xfer_end_i, xfer_end_ack_i, ack_fail_i,
       addr_match_i, xfer_ctrl_svc_i} = s;
      @(negedge clock_i);
      {arb_lost_i, rw_valid_i, xfer_end_i, xfer_end_ack_i, ack_fail_i,
       addr_match_i, xfer_ctrl_svc_i} = 7'h00;
      repeat (2) @(negedge clock_i);
   endtask

   function automatic logic pick(input int w);
      return (w == 0) ? bus_busy_flag_o :
             (w == 1) ? sda_oe_n_o : scl_oe_n_o;
   endfunction

   task automatic waitv(input int w, input logic v, input int n);
      for (int i = 0; i < n && pick(w) !== v; i++) @(negedge clock_i);
   endtask

   task automatic chk_reset();
      chk("master", 0, master_select_o);
      chk("transmit", 0, transmit_select_o);
      chk("busy", 0, bus_busy_flag_o);
      chk("irq flag", 0, interface_irq_flag_o);
      chk("mode", 4'h1, mode_o);
      chk("irq out", 0, irq_o);
      chk("idle drive", 4'h3, {scl_oe_n_o, sda_oe_n_o});
   endtask

   ////////////////////////////////////////////////////////////////////////
   localparam logic [14:0] CFG = 15'b000_100_010_001_000;
   localparam logic [34:0] SRC = {7'h08, 7'h10, 7'h10, 7'h04, 7'h10};
   localparam logic [4:0] EXP = 5'b11110;

   initial begin
      {sys_rst_i, wr_i, rd_i, wr_master_i, wr_transmit_i, wr_busy_i,
       wr_qual_i, wr_irq_i, arb_lost_i, xfer_end_i, xfer_end_ack_i,
       addr_match_i, rw_bit_i, rw_valid_i, transfer_format_sel_i,
       wait_insert_i, ack_check_enable_i, ack_fail_i, xfer_ctrl_svc_i,
       display_channel_switch_i, irq_enable_i} = '0;
      sys_rst_i = 1'b1;
      repeat (16) @(negedge clock_i);
      sys_rst_i = 1'b0;
      chk_reset();
      for (int n = 0; n < 4; n++) begin
         wr(n[1], n[0], 1'b0, 1'b1, 1'b0);
         chk("mode", 4'h1 << n, mode_o);
      end
      wr(0, 0, 0, 1, 0);
      irq_enable_i = 1'b1;
      peer.start_frame();
      @(negedge clock_i);
      waitv(0, 1'b1, 20);
      chk("busy", 1, bus_busy_flag_o);
      chk("starts", 1, n_start[3:0]);
      peer.send_byte(8'ha5);
      peer.stop_frame();
      @(negedge clock_i);
      waitv(0, 1'b0, 20);
      chk("busy", 0, bus_busy_flag_o);
      chk("stops", 1, n_stop[3:0]);
      chk("irq flag", 1, interface_irq_flag_o);
      chk("irq out", 1, irq_o);
      irq_enable_i = 1'b0;
      @(negedge clock_i);
      chk("irq out", 0, irq_o);
      wr(0, 0, 0, 1, 0);
      chk("irq flag", 1, interface_irq_flag_o);
      rd();
      wr(0, 0, 0, 1, 0);
      chk("irq flag", 0, interface_irq_flag_o);
      rw_bit_i = 1'b1;
      pulse(7'h20);
      chk("transmit", 1, transmit_select_o);
      wr(0, 0, 0, 1, 0);
      chk("transmit", 1, transmit_select_o);
      rd();
      wr(0, 0, 0, 1, 0);
      chk("transmit", 0, transmit_select_o);
      wr(0, 1, 0, 1, 0);
      display_channel_switch_i = 1'b1;
      repeat (4) @(negedge clock_i);
      display_channel_switch_i = 1'b0;
      repeat (4) @(negedge clock_i);
      chk("transmit", 0, transmit_select_o);
      rd();
      wr(1, 1, 0, 1, 0);
      pulse(7'h40);
      chk("master", 0, master_select_o);
      chk("transmit", 0, transmit_select_o);
      chk("irq flag", 1, interface_irq_flag_o);
      wr(1, 1, 0, 1, 0);
      chk("master", 0, master_select_o);
      chk("transmit", 0, transmit_select_o);
      rd();
      wr(1, 1, 0, 1, 0);
      chk("master", 1, master_select_o);
      chk("transmit", 1, transmit_select_o);
      pulse(7'h01);
      chk("irq flag", 0, interface_irq_flag_o);
      for (int n = 0; n < 5; n++) begin
         {transfer_format_sel_i, wait_insert_i, ack_check_enable_i} =
            CFG[3*n +: 3];
         pulse(SRC[7*n +: 7]);
         chk("irq source", EXP[n], interface_irq_flag_o);
         pulse(7'h01);
      end
      wr(1, 1, 1, 0, 0);
      waitv(1, 1'b0, 4);
      chk("start sda", 0, sda_oe_n_o);
      chk("start scl", 1, scl_oe_n_o);
      waitv(0, 1'b1, 10);
      chk("busy", 1, bus_busy_flag_o);
      waitv(1, 1'b1, 4 * HOLD + 8);
      chk("start sda off", 1, sda_oe_n_o);
      chk("start scl low", 0, scl_oe_n_o);
      waitv(2, 1'b1, 2 * HOLD + 4);
      chk("start done", 1, scl_oe_n_o);
      chk("busy", 1, bus_busy_flag_o);
      chk("stops", 1, n_stop[3:0]);
      chk("irq flag", 0, interface_irq_flag_o);
      wr(1, 1, 0, 0, 0);
      waitv(1, 1'b0, 4);
      chk("stop sda", 0, sda_oe_n_o);
      chk("stop scl", 0, scl_oe_n_o);
      waitv(0, 1'b0, 4 * HOLD + 12);
      chk("busy", 0, bus_busy_flag_o);
      chk("starts", 2, n_start[3:0]);
      chk("stops", 2, n_stop[3:0]);
      chk("irq flag", 1, interface_irq_flag_o);
      pulse(7'h01);
      wr(0, 0, 0, 1, 0);
      wr(0, 0, 1, 0, 0);
      k = 0;
      repeat (2 * HOLD + 4) begin
         @(negedge clock_i);
         if (sda_oe_n_o !== 1'b1) k++;
      end
      chk("slave start", 0, k[3:0]);
      chk("busy", 0, bus_busy_flag_o);
      pulse(7'h02);
      chk("irq flag", 1, interface_irq_flag_o);
      sys_rst_i = 1'b1;
      repeat (4) @(negedge clock_i);
      sys_rst_i = 1'b0;
      chk_reset();
      report_and_stop();
   end

   initial begin
      #400_000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
